/* File: hw/fir17_params.svh */
// Purpose: Named constants of the 17-tap sample filter.
// Assumes: Included by bare name from the package and design modules.
// Notes:   Coefficients are Q15 integers, tap 0 meets the newest sample.
`ifndef FIR17_PARAMS_SVH
`define FIR17_PARAMS_SVH

`define FIR_DATA_W      16
`define FIR_TAPS        17
`define FIR_ACC_W       40
`define FIR_Q_SHIFT     15
`define FIR_ROUND_BIT   14
`define FIR_OUT_DEPTH   16
`define FIR_SETTLE_CYC  4'h4
`define FIR_LAST_TAP    5'h10
`define FIR_FIRST_TAP   5'h00

// Q15 coefficient table, tap 0 .. tap 16
`define FIR_COEF_ROM '{16'he287, 16'h13f5, 16'h1c4f, 16'h0e53, \
   16'hf19b, 16'hecfc, 16'h1a33, 16'h5ed7, 16'h7fff, 16'h5ed7, \
   16'h1a32, 16'hecfc, 16'hf19b, 16'h0e53, 16'h1c4f, 16'h13f5, \
   16'he287}

`endif

/* File: hw/fir17_pkg.sv */
// Purpose: Types shared by the sample filter and its output buffer.
// Assumes: fir17_params.svh supplies the numeric constants.
// Notes:   Sequencer states use explicit binary codes.
`include "fir17_params.svh"

package fir17_pkg;

   typedef logic signed [`FIR_DATA_W-1:0] sample_t;

   // Word handed to the output buffer
   typedef struct packed {
      sample_t value;
   } out_word_t;

   typedef enum logic [2:0] {
      st_load   = 3'h0,
      st_wait   = 3'h1,
      st_read   = 3'h2,
      st_hold   = 3'h3,
      st_capt   = 3'h4,
      st_mac    = 3'h5,
      st_round  = 3'h6,
      st_emit   = 3'h7
   } fir_state_t;

endpackage

/* File: hw/fir_out_fifo.sv */
// Purpose: Small FIFO between the filter and the D/A converter.
// Assumes: Single clock; DEPTH is a power of two.
// Notes:   Read data come from a register; storage plus one output stage.
`include "fir17_params.svh"

module fir_out_fifo import fir17_pkg::*; #(
   parameter int WIDTH = `FIR_DATA_W,
   parameter int DEPTH = `FIR_OUT_DEPTH
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data,
   // Status
   output logic                  full,
   output logic                  empty
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0]   count;
   logic             push;
   logic             pop;

   // Refuse shapes the pointer wrap cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("fir_out_fifo: DEPTH must be a power of two >= 2");
   end

   // Handshakes; full stalls the filter's emit step
   assign full     = (count == (PTR_W+1)'(DEPTH));
   assign empty    = (count == '0);
   assign in_ready = !full;
   assign push     = in_valid && in_ready;
   assign pop      = !empty && (!out_valid || out_ready);

   // Storage write
   always_ff @(posedge clk_sys) begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   // Pointers and fill level
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

   // Registered output stage
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else if (pop) begin
         out_valid <= 1'b1;
         out_data  <= mem[rd_ptr];
      end else if (out_ready) begin
         out_valid <= 1'b0;
      end
   end

endmodule

/* File: hw/fir17_sample_filter.sv */
// Purpose: 17-tap Q15 FIR filter, one output word per input sample.
// Assumes: Input FIFO data stable two cycles after a read strobe.
// Notes:   One multiply-accumulate per clock; 17 MAC cycles in at least 23 per sample.
// Function
// R1: Output is sum of 17 products, current plus 16 previous samples.
// R2: Coefficients are signed Q15 integers, weight is value times 2^-15.
// R3: Symmetric table, centre 32767, neighbours 24279, outer taps -7545; the table holds 6707 at tap 6 but 6706 at tap 10.
// R4: Copy coefficient table to working storage, one entry per step.
// R5: Input FIFO empty flag drives wait_condition_input.
// R6: Poll while FIFO empty, read exactly one sample once data exists.
// R7: Delay line advances during accumulation, no separate shift pass.
// R8: Round by adding half an output LSB before storing.
// R9: Write result to D/A, return to waiting; one output per input.
// R10: Output is 16-bit signed after removing Q15 scale; wraps on overflow.
`include "fir17_params.svh"

module fir17_sample_filter import fir17_pkg::*; #(
   parameter int TAPS      = `FIR_TAPS,
   parameter int OUT_DEPTH = `FIR_OUT_DEPTH
) (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   // Input sample FIFO
   input  wire logic                  wait_condition_input,
   input  wire logic [`FIR_DATA_W-1:0] in_sample,
   output logic                       in_read,
   // D/A converter
   output logic [`FIR_DATA_W-1:0]     dac_data,
   output logic                       dac_valid,
   input  wire logic                  dac_ready,
   // Status
   output logic                       coef_ready
);
   // Fixed table; coef holds the working copy made after reset
   localparam sample_t COEF_ROM [`FIR_TAPS] = `FIR_COEF_ROM; // R3
   // Half an output LSB, added once after the last product
   localparam logic signed [`FIR_ACC_W-1:0] HALF_LSB =
      `FIR_ACC_W'(1) <<< `FIR_ROUND_BIT;

   // Sequencer, table copy and delay-line state
   fir_state_t                state;
   sample_t                   coef [`FIR_TAPS];
   sample_t                   taps [`FIR_TAPS];
   logic [4:0]                idx;
   logic [3:0]                settle;
   logic signed [`FIR_ACC_W-1:0] acc;
   logic                      empty_s1;
   logic                      empty_s2;
   logic                      empty_s3;
   logic                      empty_flt;
   out_word_t                 result;
   logic                      result_ok;
   logic                      fifo_in_ready;

   // The table is fixed at 17 entries, so other tap counts are refused
   if (TAPS != `FIR_TAPS) begin
      $error("fir17_sample_filter: TAPS must equal the table size");
   end
   // The output buffer wraps its pointers, so depth is a power of two
   if (OUT_DEPTH < 2 || (OUT_DEPTH & (OUT_DEPTH - 1)) != 0) begin
      $error("fir17_sample_filter: OUT_DEPTH must be a power of two");
   end

   // Signed 16x16 product widened to the accumulator (Q15 * Q0)
   function automatic logic signed [`FIR_ACC_W-1:0] mac_term(
      input sample_t c,
      input sample_t x
   );
      logic signed [2*`FIR_DATA_W-1:0] p;
      p = c * x; // R2
      return `FIR_ACC_W'(p);
   endfunction

   // Next tap up, for the load count and the delay-line move
   function automatic logic [4:0] tap_above(input logic [4:0] i);
      return i + 5'h01;
   endfunction

   // Empty flag from the input FIFO crosses in through three flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         empty_s1 <= 1'b1;
         empty_s2 <= 1'b1;
         empty_s3 <= 1'b1;
      end else begin
         empty_s1 <= wait_condition_input; // R5
         empty_s2 <= empty_s1;
         empty_s3 <= empty_s2;
      end
   end

   // Filtered level: only a change seen by two stages counts
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         empty_flt <= 1'b1;
      else if (empty_s2 == empty_s3)
         empty_flt <= empty_s3;
   end

   // Sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= st_load;
      end else begin
         unique case (state)
            st_load: begin
               if (idx == `FIR_LAST_TAP)
                  state <= st_wait; // R4
            end
            st_wait: begin
               // Settle hides the flag lag after our own read
               if (!empty_flt && settle == '0)
                  state <= st_read; // R6
            end
            st_read:  state <= st_hold;
            st_hold:  state <= st_capt;
            st_capt:  state <= st_mac;
            st_mac: begin
               if (idx == `FIR_FIRST_TAP)
                  state <= st_round;
            end
            st_round: state <= st_emit;
            st_emit: begin
               if (fifo_in_ready)
                  state <= st_wait; // R9
            end
         endcase
      end
   end

   // Step index: counts up while loading, down while accumulating
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         idx <= `FIR_FIRST_TAP;
      else if (state == st_load && idx != `FIR_LAST_TAP)
         idx <= tap_above(idx);
      else if (state == st_capt)
         idx <= `FIR_LAST_TAP;
      else if (state == st_mac && idx != `FIR_FIRST_TAP)
         idx <= idx - 5'h01;
   end

   // Coefficient copy from the constant table, one word per cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < `FIR_TAPS; i++)
            coef[i] <= '0;
      end else if (state == st_load) begin
         coef[idx] <= COEF_ROM[idx]; // R4
      end
   end

   // Coefficients usable once the copy is complete
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         coef_ready <= 1'b0;
      else if (state == st_load && idx == `FIR_LAST_TAP)
         coef_ready <= 1'b1;
   end

   // Read strobe to the input FIFO, exactly one per sample
   assign in_read = (state == st_read); // R6

   // Hold-off after a read so the slow flag cannot cause a second read
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         settle <= '0;
      else if (state == st_read)
         settle <= `FIR_SETTLE_CYC;
      else if (settle != '0)
         settle <= settle - 4'h1;
   end

   // Delay line: newest into tap 0, each tap below tap 16 moves on as it is used
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < `FIR_TAPS; i++)
            taps[i] <= '0;
      end else if (state == st_capt) begin
         taps[0] <= sample_t'(in_sample);
      end else if (state == st_mac && idx != `FIR_LAST_TAP) begin
         taps[tap_above(idx)] <= taps[idx]; // R7
      end
   end

   // Accumulator: cleared on capture, one product per cycle, then round
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         acc <= '0;
      else if (state == st_capt)
         acc <= '0;
      else if (state == st_mac)
         acc <= acc + mac_term(coef[idx], taps[idx]); // R1
      else if (state == st_round)
         acc <= acc + HALF_LSB; // R8
   end

   // Scale back from Q15; upper bits are dropped, so overflow wraps
   always_comb begin
      result.value = acc[`FIR_Q_SHIFT +: `FIR_DATA_W]; // R10
   end

   // Offer the result to the output buffer until it is accepted
   assign result_ok = (state == st_emit); // R9

   // Output buffer; when full it stalls the emit step
   fir_out_fifo #(
      .WIDTH (`FIR_DATA_W),
      .DEPTH (OUT_DEPTH)
   ) u_out_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (result_ok),
      .in_ready  (fifo_in_ready),
      .in_data   (result.value),
      .out_valid (dac_valid),
      .out_ready (dac_ready),
      .out_data  (dac_data),
      .full      (),
      .empty     ()
   );

endmodule

/* File: verification/fir17_monitor.sv */
// Purpose: Port checks of the FIR sample filter.
// Assumes: One clock; reset_n async, active low.
// Notes:   Bound to every filter instance.
`include "fir17_params.svh"
module fir17_monitor #(
   parameter int TAPS      = 17,
   parameter int OUT_DEPTH = 16
) (
   // Clock and reset
   input wire logic                   clk_sys,
   input wire logic                   reset_n,
   // Filter ports
   input wire logic                   wait_condition_input,
   input wire logic [`FIR_DATA_W-1:0] in_sample,
   input wire logic                   in_read,
   input wire logic [`FIR_DATA_W-1:0] dac_data,
   input wire logic                   dac_valid,
   input wire logic                   dac_ready,
   input wire logic                   coef_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   int ins;
   int outs;
   // Reads and taken words, to pair them up
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ins  <= 0;
         outs <= 0;
      end else begin
         ins  <= ins + int'(in_read);
         outs <= outs + int'(dac_valid && dac_ready);
      end
   end
   read_pulse_a: assert property (in_read |=> !in_read [*8])
      else $error("read strobe too long or too close");
   empty_read_a: assert property (
      wait_condition_input [*6] |=> !in_read)
      else $error("read while source empty");
   coef_first_a: assert property (!coef_ready |-> !in_read)
      else $error("read before coefficient load");
   coef_time_a: assert property (
      $rose(reset_n) |-> ##[16:18] coef_ready)
      else $error("coefficient load time wrong");
   coef_keep_a: assert property (coef_ready |=> coef_ready)
      else $error("coefficient ready dropped");
   out_pair_a: assert property (
      outs <= ins && ins - outs <= OUT_DEPTH + 2)
      else $error("outputs do not pair with inputs");
   dac_hold_a: assert property (
      dac_valid && !dac_ready |=> dac_valid && $stable(dac_data))
      else $error("output word changed before taken");
   first_out_a: assert property (
      in_read && !dac_valid |-> ##[21:25] dac_valid)
      else $error("output word late");
   valid_drop_a: assert property (
      $fell(dac_valid) |-> $past(dac_ready))
      else $error("output word lost");
endmodule

bind fir17_sample_filter fir17_monitor #(
   .TAPS(TAPS), .OUT_DEPTH(OUT_DEPTH)) mon (
   .clk_sys(clk_sys), .reset_n(reset_n),
   .wait_condition_input(wait_condition_input),
   .in_sample(in_sample), .in_read(in_read), .dac_data(dac_data),
   .dac_valid(dac_valid), .dac_ready(dac_ready),
   .coef_ready(coef_ready));

/* File: verification/fir_stream_partner.sv */
// Purpose: Input sample FIFO and D/A converter beside the filter.
// Assumes: Bench pushes one sample per push_en cycle.
// Notes:   Read data hold two cycles, then turn over each cycle.
module fir_stream_partner (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Bench side
   input  wire logic        push_en,
   input  wire logic [15:0] push_val,
   input  wire logic        stall,
   // Filter side
   input  wire logic        in_read,
   output logic             wait_condition_input,
   output logic [15:0]      in_sample,
   output logic             dac_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] q[$];
   logic [1:0]  hold;
   // Converter takes a word unless stalled
   assign dac_ready = !stall;
   // Stale data flips so a late capture shows up
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         q.delete();
         hold <= 2'h0;
         in_sample <= 16'h0;
         wait_condition_input <= 1'b1;
      end else begin
         if (push_en) q.push_back(push_val);
         if (in_read && q.size() != 0) begin
            in_sample <= q.pop_front();
            hold <= 2'h2;
         end else if (hold != 2'h0) hold <= hold - 2'h1;
         else in_sample <= ~in_sample;
         wait_condition_input <= (q.size() == 0);
      end
   end
endmodule

/* File: verification/test_fir17_sample_filter.sv */
// Purpose: Self-checking bench of the FIR sample filter.
// Assumes: Integer model of the taps, fed as the design is.
// Notes:   Random stalls on the converter side.
module test_fir17_sample_filter import fir17_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, reset_n = 0, push_en = 0, stall = 0;
   logic hs = 0, rs = 0, in_read, dac_valid, dac_ready;
   logic coef_ready, wait_condition_input;
   logic [15:0] push_val = 16'h0, dac_data, in_sample;
   int fails = 0, checks = 0, seed = 32'h37fa;
   int hist[17];
   logic [15:0] exp_q[$];
   const int coef[17] = '{-7545, 5109, 7247, 3667, -3685, -4868,
      6707, 24279, 32767, 24279, 6706, -4868, -3685, 3667, 7247,
      5109, -7545};
   always #4 clk_sys = ~clk_sys;
   fir17_sample_filter dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .wait_condition_input(wait_condition_input),
      .in_sample(in_sample), .in_read(in_read), .dac_data(dac_data),
      .dac_valid(dac_valid), .dac_ready(dac_ready),
      .coef_ready(coef_ready));
   fir_stream_partner far (.clk_sys(clk_sys), .reset_n(reset_n),
      .push_en(push_en), .push_val(push_val), .stall(stall),
      .in_read(in_read), .wait_condition_input(wait_condition_input),
      .in_sample(in_sample), .dac_ready(dac_ready));
   task cmp(string n, logic [15:0] e, logic [15:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Model: newest sample meets tap 0, half LSB added
   task feed(logic [15:0] v);
      longint acc;
      @(posedge clk_sys);
      push_en <= 1'b1;
      push_val <= v;
      for (int k = 16; k > 0; k--) hist[k] = hist[k-1];
      hist[0] = int'(signed'(v));
      acc = 16384;
      for (int k = 0; k < 17; k++) acc += longint'(coef[k]) * hist[k];
      acc = acc >>> 15;
      exp_q.push_back(acc[15:0]);
   endtask
   task drain(string n);
      int i;
      @(posedge clk_sys);
      push_en <= 1'b0;
      i = 0;
      while (exp_q.size() != 0 && i < 4000) begin
         @(posedge clk_sys);
         i++;
      end
      cmp("outputs_missing", 16'h0, 16'(exp_q.size()));
      if (exp_q.size() != 0) test_done;
      else $display("test %s done", n);
   endtask
   task rst(string n);
      reset_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      exp_q.delete();
      hist = '{default: 0};
      cmp("in_read", 16'h0, {15'h0, in_read});
      cmp("dac_valid", 16'h0, {15'h0, dac_valid});
      reset_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
      #1 cmp("coef_ready", 16'h0, {15'h0, coef_ready});
      repeat (8) @(posedge clk_sys);
      #1 cmp("coef_ready", 16'h1, {15'h0, coef_ready});
      $display("test %s done", n);
   endtask
   // Converter stalls: held, random, or none
   always @(posedge clk_sys) stall <= hs || (rs && $random(seed) % 2 != 0);
   // Every word taken is checked in order
   always @(posedge clk_sys) begin
      if (reset_n && dac_valid && dac_ready) begin
         if (exp_q.size() == 0) cmp("extra_word", 16'h0, 16'h1);
         else cmp("dac_data", exp_q.pop_front(), dac_data);
      end
   end
   initial begin
      rst("reset");
      feed(16'h7fff);
      repeat (16) feed(16'h0);
      drain("impulse");
      feed(16'h8000);
      repeat (16) feed(16'h0);
      drain("neg_impulse");
      for (int k = 0; k < 17; k++) feed(coef[16-k] < 0 ? 16'h8000 : 16'h7fff);
      drain("wrap");
      rs <= 1'b1;
      repeat (40) feed(16'($random(seed)));
      drain("random");
      rs <= 1'b0;
      hs <= 1'b1;
      repeat (24) feed(16'($random(seed)));
      @(posedge clk_sys);
      push_en <= 1'b0;
      repeat (800) @(posedge clk_sys);
      #1 cmp("dac_valid", 16'h1, {15'h0, dac_valid});
      cmp("source_left", 16'h0, {15'h0, wait_condition_input});
      hs <= 1'b0;
      drain("full");
      repeat (5) feed(16'($random(seed)));
      drain("pre_reset");
      rst("mid_reset");
      repeat (17) feed(16'($random(seed)));
      drain("after_reset");
      test_done;
   end
endmodule
